// [hspwm_top.sv]
// Module: two PWM generators, four high-side output source selectors and fault filters
module hspwm_top #(
  parameter int OC_CYC = hspwm_pkg::OC_FILT_CYC,
  parameter int OL_CYC = hspwm_pkg::OL_FILT_CYC,
  parameter int DIV_LO = hspwm_pkg::STEP_DIV_LO
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] sbc_mode,
  input  wire logic       timer1_in,
  input  wire logic       timer2_in,
  input  wire logic [3:0] oc_sense,
  input  wire logic [3:0] ol_sense,
  output logic      [3:0] high_side_output,
  output logic            irq
);
  localparam int NO = hspwm_pkg::NUM_OUT;
  localparam int FW = hspwm_pkg::FIELD_W;
  localparam int DW = hspwm_pkg::DUTY_W;
  localparam int DIV_HI = DIV_LO / 2;
  localparam int DVW = $clog2(DIV_LO + 1);

  logic [DW-1:0]    gen1_duty_setting;
  logic [DW-1:0]    gen2_duty_setting;
  logic [1:0]       generator_rate_select;
  logic [FW*NO-1:0] output_source_field;
  logic [NO-1:0]    oc_stat_r;
  logic [NO-1:0]    ol_stat_r;
  logic [1:0]       irq_stat_r;
  logic [1:0]       irq_en_r;
  logic [3:0]       oc_s1_r;
  logic [3:0]       oc_s2_r;
  logic [3:0]       oc_s3_r;
  logic [3:0]       ol_s1_r;
  logic [3:0]       ol_s2_r;
  logic [3:0]       ol_s3_r;
  logic [3:0]       oc_clean_r;
  logic [3:0]       ol_clean_r;
  logic [1:0]       tm_s1_r;
  logic [1:0]       tm_s2_r;
  logic [1:0]       tm_s3_r;
  logic [1:0]       tm_clean_r;
  logic [NO-1:0]    oc_hit;
  logic [NO-1:0]    ol_hit;
  logic [NO-1:0]    oc_hit_d_r;
  logic [NO-1:0]    ol_hit_d_r;
  logic [DVW-1:0]   div1_r;
  logic [DVW-1:0]   div2_r;
  logic [DW-1:0]    cnt1_r;
  logic [DW-1:0]    cnt2_r;
  logic [1:0]       pwm_r;
  logic [NO-1:0]    drive;
  logic             cfg_wr_ok;
  logic             outs_off;
  // Per-register write decodes
  logic             wr_gen1;
  logic             wr_gen2;
  logic             wr_rate;
  logic             wr_src_a;
  logic             wr_src_b;
  logic             clr_oc;
  logic             clr_ol;
  logic             clr_irq;
  logic             wr_irq_en;

  // Only normal mode accepts config; stop and sleep keep it frozen
  assign cfg_wr_ok = reg_wr && (sbc_mode == hspwm_pkg::MODE_NORMAL);
  assign outs_off  = (sbc_mode == hspwm_pkg::MODE_RESTART) ||
                     (sbc_mode == hspwm_pkg::MODE_FAILSAFE);

  // Setup writes need normal mode; fault clears and interrupt setup work in any mode
  assign wr_gen1   = cfg_wr_ok && (reg_addr == hspwm_pkg::ADDR_GEN1_DUTY);
  assign wr_gen2   = cfg_wr_ok && (reg_addr == hspwm_pkg::ADDR_GEN2_DUTY);
  assign wr_rate   = cfg_wr_ok && (reg_addr == hspwm_pkg::ADDR_RATE_SEL);
  assign wr_src_a  = cfg_wr_ok && (reg_addr == hspwm_pkg::ADDR_SRC_CTRL_A);
  assign wr_src_b  = cfg_wr_ok && (reg_addr == hspwm_pkg::ADDR_SRC_CTRL_B);
  assign clr_oc    = reg_wr && (reg_addr == hspwm_pkg::ADDR_OC_STAT);
  assign clr_ol    = reg_wr && (reg_addr == hspwm_pkg::ADDR_OL_STAT);
  assign clr_irq   = reg_wr && (reg_addr == hspwm_pkg::ADDR_IRQ_CLR);
  assign wr_irq_en = reg_wr && (reg_addr == hspwm_pkg::ADDR_IRQ_EN);

  // Pin inputs pass three flops; a change counts when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oc_s1_r    <= 4'h0;
      oc_s2_r    <= 4'h0;
      oc_s3_r    <= 4'h0;
      oc_clean_r <= 4'h0;
      ol_s1_r    <= 4'h0;
      ol_s2_r    <= 4'h0;
      ol_s3_r    <= 4'h0;
      ol_clean_r <= 4'h0;
      tm_s1_r    <= 2'h0;
      tm_s2_r    <= 2'h0;
      tm_s3_r    <= 2'h0;
      tm_clean_r <= 2'h0;
    end else begin
      oc_s1_r <= oc_sense;
      oc_s2_r <= oc_s1_r;
      oc_s3_r <= oc_s2_r;
      oc_clean_r <= (oc_s2_r & oc_s3_r) | (oc_clean_r & (oc_s2_r | oc_s3_r));
      ol_s1_r <= ol_sense;
      ol_s2_r <= ol_s1_r;
      ol_s3_r <= ol_s2_r;
      ol_clean_r <= (ol_s2_r & ol_s3_r) | (ol_clean_r & (ol_s2_r | ol_s3_r));
      // Timer levels come from outside this clock as well
      tm_s1_r <= {timer2_in, timer1_in};
      tm_s2_r <= tm_s1_r;
      tm_s3_r <= tm_s2_r;
      tm_clean_r <= (tm_s2_r & tm_s3_r) | (tm_clean_r & (tm_s2_r | tm_s3_r));
    end
  end

  // Duty and rate registers, writable only in normal mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gen1_duty_setting     <= 8'h00;
      gen2_duty_setting     <= 8'h00;
      generator_rate_select <= 2'h0;
    end else begin
      if (wr_gen1) begin
        gen1_duty_setting <= reg_wdata;
      end
      if (wr_gen2) begin
        gen2_duty_setting <= reg_wdata;
      end
      if (wr_rate) begin
        generator_rate_select <= reg_wdata[1:0];
      end
    end
  end

  // Step dividers: bit set selects 400 Hz, which halves the step interval
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div1_r <= '0;
      div2_r <= '0;
      cnt1_r <= 8'h00;
      cnt2_r <= 8'h00;
    end else begin
      if (div1_r >= DVW'((generator_rate_select[0] ? DIV_HI : DIV_LO) - 1)) begin
        div1_r <= '0;
        cnt1_r <= cnt1_r + 8'h01;  // 256 steps wrap naturally
      end else begin
        div1_r <= div1_r + DVW'(1);
      end
      if (div2_r >= DVW'((generator_rate_select[1] ? DIV_HI : DIV_LO) - 1)) begin
        div2_r <= '0;
        cnt2_r <= cnt2_r + 8'h01;
      end else begin
        div2_r <= div2_r + DVW'(1);
      end
    end
  end

  // Generator outputs high while the step count is below the duty value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwm_r <= 2'h0;
    end else begin
      pwm_r[0] <= cnt1_r < gen1_duty_setting;
      pwm_r[1] <= cnt2_r < gen2_duty_setting;
    end
  end

  // Fault filters counted in internal oscillator cycles
  for (genvar i = 0; i < NO; i++) begin : g_filt
    hspwm_filter #(.FILT_CYC(OC_CYC)) u_oc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cond    (oc_clean_r[i] && drive[i]),
      .hit     (oc_hit[i])
    );
    hspwm_filter #(.FILT_CYC(OL_CYC)) u_ol (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cond    (ol_clean_r[i] && drive[i]),
      .hit     (ol_hit[i])
    );
  end

  // Source fields: written in normal mode, cleared by overcurrent shutdown, restart or fail-safe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_source_field <= '0;
      oc_hit_d_r          <= '0;
    end else begin
      oc_hit_d_r <= oc_hit;
      for (int i = 0; i < NO; i++) begin
        if (outs_off) begin
          output_source_field[i*FW +: FW] <= hspwm_pkg::SRC_OFF;
        end else if (oc_hit[i]) begin
          output_source_field[i*FW +: FW] <= hspwm_pkg::SRC_OFF;
        end else if (wr_src_a && i < 2) begin
          output_source_field[i*FW +: FW] <= reg_wdata[(i%2)*4 +: FW];
        end else if (wr_src_b && i >= 2) begin
          output_source_field[i*FW +: FW] <= reg_wdata[(i%2)*4 +: FW];
        end
      end
    end
  end

  // Source mux; assignment takes effect on the next cycle, no waiting for a period
  always_comb begin
    for (int i = 0; i < NO; i++) begin
      case (output_source_field[i*FW +: FW])
        hspwm_pkg::SRC_ON:   drive[i] = 1'b1;
        hspwm_pkg::SRC_TMR1: drive[i] = tm_clean_r[0];
        hspwm_pkg::SRC_TMR2: drive[i] = tm_clean_r[1];
        hspwm_pkg::SRC_PWM1: drive[i] = pwm_r[0];
        hspwm_pkg::SRC_PWM2: drive[i] = pwm_r[1];
        default:             drive[i] = 1'b0;
      endcase
    end
  end

  // Registered outputs; open load never switches an output off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_side_output <= 4'h0;
    end else begin
      high_side_output <= (outs_off ? 4'h0 : drive) & ~oc_hit;
    end
  end

  // Sticky fault flags: hardware set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oc_stat_r  <= '0;
      ol_stat_r  <= '0;
      ol_hit_d_r <= '0;
    end else begin
      ol_hit_d_r <= ol_hit;
      oc_stat_r <= (clr_oc ? oc_stat_r & ~reg_wdata[NO-1:0] : oc_stat_r) |
                   oc_hit;
      ol_stat_r <= (clr_ol ? ol_stat_r & ~reg_wdata[NO-1:0] : ol_stat_r) |
                   ol_hit;
    end
  end

  // Interrupt enable: software only, writable in any mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_en_r <= 2'h0;
    end else if (wr_irq_en) begin
      irq_en_r <= reg_wdata[1:0];
    end
  end

  // Interrupt status: bit 0 new overcurrent, bit 1 new open load; set beats clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (clr_irq ? irq_stat_r & ~reg_wdata[1:0] : irq_stat_r) |
                    {|(ol_hit & ~ol_hit_d_r), |(oc_hit & ~oc_hit_d_r)};
      irq <= |(irq_stat_r & irq_en_r);  // Registered, so one cycle behind status
    end
  end

  // Read port: data in the cycle after the read strobe, unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        hspwm_pkg::ADDR_GEN1_DUTY:  reg_rdata <= gen1_duty_setting;
        hspwm_pkg::ADDR_GEN2_DUTY:  reg_rdata <= gen2_duty_setting;
        hspwm_pkg::ADDR_RATE_SEL:   reg_rdata <= {6'h00, generator_rate_select};
        hspwm_pkg::ADDR_SRC_CTRL_A: reg_rdata <= {1'b0, output_source_field[5:3],
                                                  1'b0, output_source_field[2:0]};
        hspwm_pkg::ADDR_SRC_CTRL_B: reg_rdata <= {1'b0, output_source_field[11:9],
                                                  1'b0, output_source_field[8:6]};
        hspwm_pkg::ADDR_OC_STAT:    reg_rdata <= {4'h0, oc_stat_r};
        hspwm_pkg::ADDR_OL_STAT:    reg_rdata <= {4'h0, ol_stat_r};
        hspwm_pkg::ADDR_IRQ_STAT:   reg_rdata <= {6'h00, irq_stat_r};
        hspwm_pkg::ADDR_IRQ_EN:     reg_rdata <= {6'h00, irq_en_r};
        default:                    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : hspwm_top

// [hspwm_pkg.sv]
// Package: constants shared by the high-side PWM and output assignment block
package hspwm_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_GEN1_DUTY   = 4'h0;
  localparam logic [3:0] ADDR_GEN2_DUTY   = 4'h1;
  localparam logic [3:0] ADDR_RATE_SEL    = 4'h2;
  localparam logic [3:0] ADDR_SRC_CTRL_A  = 4'h3;
  localparam logic [3:0] ADDR_SRC_CTRL_B  = 4'h4;
  localparam logic [3:0] ADDR_OC_STAT     = 4'h5;
  localparam logic [3:0] ADDR_OL_STAT     = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STAT    = 4'h7;
  localparam logic [3:0] ADDR_IRQ_CLR     = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN      = 4'h9;
  // Output source field encodings, three bits each
  localparam logic [2:0] SRC_OFF   = 3'h0;
  localparam logic [2:0] SRC_ON    = 3'h1;
  localparam logic [2:0] SRC_TMR1  = 3'h2;
  localparam logic [2:0] SRC_TMR2  = 3'h3;
  localparam logic [2:0] SRC_PWM1  = 3'h4;
  localparam logic [2:0] SRC_PWM2  = 3'h5;
  localparam int         FIELD_W   = 3;
  localparam int         NUM_OUT   = 4;
  localparam int         DUTY_W    = 8;
  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int OSC_HZ_PER_US = CLK_HZ / 1_000_000;
  localparam int OC_FILT_US    = 16;
  localparam int OL_FILT_US    = 64;
  localparam int OC_FILT_CYC   = OC_FILT_US * OSC_HZ_PER_US;
  localparam int OL_FILT_CYC   = OL_FILT_US * OSC_HZ_PER_US;
  localparam int PWM_STEPS     = 256;
  localparam int RATE_LO_HZ    = 200;
  // Step enable divisor at 200 Hz: one 256-step period per 5 ms
  localparam int STEP_DIV_LO   = CLK_HZ / (RATE_LO_HZ * PWM_STEPS);
  localparam int STEP_DIV_HI   = STEP_DIV_LO / 2;
  // SBC operating modes
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_STOP     = 3'h1;
  localparam logic [2:0] MODE_SLEEP    = 3'h2;
  localparam logic [2:0] MODE_RESTART  = 3'h3;
  localparam logic [2:0] MODE_FAILSAFE = 3'h4;
endpackage : hspwm_pkg

// [hspwm_filter.sv]
// Module: persistence filter that asserts after a condition holds a set number of cycles
module hspwm_filter #(
  parameter int FILT_CYC = 640
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic cond,
  output logic      hit
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);
  logic [CW-1:0] cnt_r;

  // Count oscillator cycles while the condition stands, restart on any gap
  always_ff @(posedge sys_clk) begin
    if (rst || !cond) begin
      cnt_r <= '0;
      hit   <= 1'b0;
    end else if (cnt_r == LAST) begin
      hit   <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
endmodule : hspwm_filter

// [hspwm_top_chk.sv]
// Checker: port-level properties of the high-side PWM block
module hspwm_top_chk #(
  parameter int OC_CYC = 8
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] sbc_mode,
  input wire logic       timer1_in,
  input wire logic       timer2_in,
  input wire logic [3:0] oc_sense,
  input wire logic [3:0] ol_sense,
  input wire logic [3:0] high_side_output,
  input wire logic       irq
);
  logic [7:0] oc_run_r;
  logic       cut_r;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Length of the current overcurrent episode on output 0
  always_ff @(posedge sys_clk) begin
    if (rst || !(oc_sense[0] && high_side_output[0]))
      oc_run_r <= 8'h00;
    else
      oc_run_r <= oc_run_r + 8'h01;
  end
  // A shutdown must hold until software writes again, not recover by itself
  always_ff @(posedge sys_clk) begin
    if (rst || reg_wr)
      cut_r <= 1'b0;
    else if (oc_run_r >= OC_CYC && !high_side_output[0])
      cut_r <= 1'b1;
  end
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_oc_bound;
    oc_run_r <= 8'(OC_CYC + 10);
  endproperty
  a_oc_bound: assert property (p_oc_bound) else $error("overcurrent not cut");
  property p_oc_keep;
    cut_r |-> !high_side_output[0];
  endproperty
  a_oc_keep: assert property (p_oc_keep) else $error("output back on after cut");
  property p_restart;
    (sbc_mode == hspwm_pkg::MODE_RESTART) [*3] |-> high_side_output == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("output on in restart");
  property p_failsafe;
    (sbc_mode == hspwm_pkg::MODE_FAILSAFE) [*3] |-> high_side_output == 4'h0;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("output on in fail-safe");
  property p_on;
    reg_wr && reg_addr == hspwm_pkg::ADDR_SRC_CTRL_A && reg_wdata[2:0] == hspwm_pkg::SRC_ON
      && sbc_mode == hspwm_pkg::MODE_NORMAL && oc_sense == 4'h0 |-> ##[1:3] high_side_output[0];
  endproperty
  a_on: assert property (p_on) else $error("output did not switch on");
  property p_off;
    reg_wr && reg_addr == hspwm_pkg::ADDR_SRC_CTRL_A && reg_wdata[2:0] == hspwm_pkg::SRC_OFF
      && sbc_mode == hspwm_pkg::MODE_NORMAL |-> ##[1:3] !high_side_output[0];
  endproperty
  a_off: assert property (p_off) else $error("output did not switch off");
  property p_ol_keep;
    high_side_output[1] && ol_sense[1] && !oc_sense[1] && !reg_wr && !$past(reg_wr)
      && sbc_mode == hspwm_pkg::MODE_NORMAL |=> high_side_output[1];
  endproperty
  a_ol_keep: assert property (p_ol_keep) else $error("open load dropped output");
  property p_irq_mask;
    reg_wr && reg_addr == hspwm_pkg::ADDR_IRQ_EN && reg_wdata == 8'h00 |-> ##3 !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt high");
endmodule : hspwm_top_chk

bind hspwm_top hspwm_top_chk #(.OC_CYC(OC_CYC)) i_chk (
  .sys_clk          (sys_clk),
  .rst              (rst),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .sbc_mode         (sbc_mode),
  .timer1_in        (timer1_in),
  .timer2_in        (timer2_in),
  .oc_sense         (oc_sense),
  .ol_sense         (ol_sense),
  .high_side_output (high_side_output),
  .irq              (irq)
);

// [hspwm_load.sv]
// Model: high-side loads that report overcurrent or open load while switched on
module hspwm_load (
  input  wire logic [3:0] sw_on,
  input  wire logic [3:0] oc_cmd,
  input  wire logic [3:0] ol_cmd,
  output logic      [3:0] oc_sense,
  output logic      [3:0] ol_sense
);
  // An off switch carries no current, so neither fault can be sensed then
  assign oc_sense = sw_on & oc_cmd;
  assign ol_sense = sw_on & ol_cmd;
endmodule : hspwm_load

// [tb_hspwm_top.sv]
// Testbench: registers, sources, PWM, faults and modes of the high-side block
module tb_hspwm_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [2:0]  sbc_mode = 3'h0;
  logic        timer1_in = 1'b0;
  logic        timer2_in = 1'b0;
  logic [3:0]  oc_on = 4'h0;
  logic [3:0]  ol_on = 4'h0;
  logic [7:0]  reg_rdata, d1, d2;
  logic [3:0]  oc_sense, ol_sense, hso, p;
  logic [2:0]  cd;
  logic [1:0]  rt;
  logic        irq;
  logic [15:0] h0, h1, e0, e1;
  int          err_total = 0;
  int          n_compared = 0;
  hspwm_top #(.OC_CYC(8), .OL_CYC(16), .DIV_LO(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sbc_mode(sbc_mode), .timer1_in(timer1_in),
    .timer2_in(timer2_in), .oc_sense(oc_sense), .ol_sense(ol_sense),
    .high_side_output(hso), .irq(irq));
  hspwm_load i_load (.sw_on(hso), .oc_cmd(oc_on), .ol_cmd(ol_on), .oc_sense(oc_sense),
    .ol_sense(ol_sense));
  always #12.5 sys_clk = ~sys_clk;
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data is only valid in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
    @(posedge sys_clk);  // Return on a rising edge so later drives stay edge-aligned
  endtask : rc
  function automatic logic f_src(input logic [2:0] c, input logic t1, input logic t2);
    return c == hspwm_pkg::SRC_ON || (c == hspwm_pkg::SRC_TMR1 && t1)
      || (c == hspwm_pkg::SRC_TMR2 && t2);
  endfunction : f_src
  // Window of 1024 cycles spans whole periods at either rate, 4 cycles per duty count
  task automatic measure();
    {h0, h1, e0, e1} = '0;
    @(negedge sys_clk);
    p = hso;
    repeat (1024) begin
      @(negedge sys_clk);
      h0 = h0 + hso[0];
      h1 = h1 + hso[1];
      e0 = e0 + (hso[0] & ~p[0]);
      e1 = e1 + (hso[1] & ~p[1]);
      p = hso;
    end
  endtask : measure
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
  initial begin
    void'($urandom(32'hf1fa45f8));
    tick(5);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rc(a[3:0], 8'h00);
    // Every plain and timer code on outputs 0 and 1
    timer1_in <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      if (c == 4 || c == 5)
        continue;
      cd = c[2:0];
      wr(hspwm_pkg::ADDR_SRC_CTRL_A, {1'b0, cd, 1'b0, cd});
      tick(8);
      chk(hso[1:0], {2{f_src(cd, 1'b1, 1'b0)}});
    end
    wr(hspwm_pkg::ADDR_SRC_CTRL_B, 8'h32);
    repeat (8) begin
      timer1_in <= 1'($urandom);
      timer2_in <= 1'($urandom);
      tick(8);
      chk(hso[3:2], {timer2_in, timer1_in});
    end
    // Generators are set up while unassigned, then assigned to outputs 0 and 1
    for (int i = 0; i < 4; i++) begin
      d1 = (i == 0) ? 8'h04 : (i == 1) ? 8'hff : 8'($urandom_range(255, 4));
      d2 = 8'($urandom_range(255, 4));
      rt = 2'($urandom);
      wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h00);
      wr(hspwm_pkg::ADDR_GEN1_DUTY, d1);
      wr(hspwm_pkg::ADDR_GEN2_DUTY, d2);
      wr(hspwm_pkg::ADDR_RATE_SEL, {6'h00, rt});
      wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h54);
      tick(1030);
      measure();
      chk(h0, {6'h00, d1, 2'h0});
      chk(h1, {6'h00, d2, 2'h0});
      chk(e0, rt[0] ? 16'h0002 : 16'h0001);
      chk(e1, rt[1] ? 16'h0002 : 16'h0001);
    end
    // Short overcurrent is filtered, a long one cuts output 0 and clears its field
    wr(hspwm_pkg::ADDR_IRQ_EN, 8'h01);
    wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h01);
    oc_on <= 4'h1;
    tick(4);
    oc_on <= 4'h0;
    tick(8);
    chk(hso[0], 16'h0001);
    oc_on <= 4'h1;
    tick(20);
    chk(hso[0], 16'h0000);
    oc_on <= 4'h0;
    rc(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h00);
    rc(hspwm_pkg::ADDR_OC_STAT, 8'h01);
    rc(hspwm_pkg::ADDR_IRQ_STAT, 8'h01);
    chk(irq, 16'h0001);
    wr(hspwm_pkg::ADDR_OC_STAT, 8'h01);
    wr(hspwm_pkg::ADDR_IRQ_CLR, 8'h01);
    tick(3);
    chk(irq, 16'h0000);
    rc(hspwm_pkg::ADDR_OC_STAT, 8'h00);
    // Open load is filtered, then flagged stickily while output 1 stays on
    wr(hspwm_pkg::ADDR_IRQ_EN, 8'h02);
    wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h10);
    ol_on <= 4'h2;
    tick(8);
    ol_on <= 4'h0;
    rc(hspwm_pkg::ADDR_OL_STAT, 8'h00);
    ol_on <= 4'h2;
    tick(40);
    chk(hso[1], 16'h0001);
    chk(irq, 16'h0001);
    ol_on <= 4'h0;
    rc(hspwm_pkg::ADDR_OL_STAT, 8'h02);
    tick(8); // Let the filtered condition lapse, else the set beats the clear
    wr(hspwm_pkg::ADDR_OL_STAT, 8'h02);
    rc(hspwm_pkg::ADDR_OL_STAT, 8'h00);
    wr(hspwm_pkg::ADDR_IRQ_EN, 8'h00);
    tick(3);
    chk(irq, 16'h0000);
    // Stop and sleep freeze the setup; restart and fail-safe turn outputs off
    for (int m = 1; m < 5; m++) begin
      sbc_mode <= m[2:0];
      wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h00);
      wr(hspwm_pkg::ADDR_GEN1_DUTY, 8'h00);
      tick(4);
      if (m < 3) begin
        rc(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h10);
        rc(hspwm_pkg::ADDR_GEN1_DUTY, d1);
        chk(hso[1], 16'h0001);
      end else begin
        chk(hso, 16'h0000);
        rc(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h00);
        sbc_mode <= 3'h0;
        wr(hspwm_pkg::ADDR_SRC_CTRL_A, 8'h10);
        tick(4);
      end
    end
    final_report();
  end
endmodule : tb_hspwm_top
